// ===== bench/tweep_host.sv
// host model driving select, shift clock and serial input
`timescale 1ns/1ps
module tweep_host (
    output logic      sel,
    output logic      sk,
    output logic      di,
    input  wire logic dout
);
    initial begin
        sel = 1'b0;
        sk  = 1'b0;
        di  = 1'b0;
    end
    // one framed access, msb first; clock stands low outside frames
    task automatic frame(input logic [24:0] v, input int n, output logic [24:0] r);
        r   = '0;
        sel = 1'b1;
        #40;
        for (int i = 0; i < n; i++) begin
            di = v[24-i];
            #20 sk = 1'b1;
            #40 sk = 1'b0;
            #20 r = {r[23:0], dout};
        end
        sel = 1'b0;
        di  = ~di;
        #300;
    endtask
    // status poll with the shift clock held still
    task automatic status(output logic first, output logic fin, output int n);
        sel = 1'b1;
        #60 first = dout;
        fin = dout;
        n   = 0;
        while (fin !== 1'b1 && n < 400) begin
            #10 fin = dout;
            n++;
        end
        #20 fin = fin && (dout === 1'b1);
        sel = 1'b0;
        #300;
    endtask
endmodule

// ===== bench/tweep_monitor.sv
// checker of the serial port pins
`timescale 1ns/1ps
module tweep_monitor #(
    parameter int WRITE_CYCLES = 50
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic SELECT_PIN,
    input wire logic SHIFT_CLOCK_PIN,
    input wire logic SERIAL_IN_PIN,
    input wire logic SERIAL_OUT,
    input wire logic SERIAL_OUT_OE_N
);
    localparam int BUSY_MAX = WRITE_CYCLES + 40;
    logic [7:0]  sk_q;
    logic [31:0] busy_q;
    wire         sk_recent = |(sk_q[6:0] & ~sk_q[7:1]);
    wire         busy_low  = !SERIAL_OUT_OE_N && !SERIAL_OUT && !sk_recent;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    always_ff @(posedge CORE_CLK) begin
        sk_q <= {sk_q[6:0], SHIFT_CLOCK_PIN};
    end
    always_ff @(posedge CORE_CLK) begin
        if (RST || !busy_low) begin
            busy_q <= 32'h0000_0000;
        end else begin
            busy_q <= busy_q + 32'h0000_0001;
        end
    end
    a_reset_release: assert property ($fell(RST) |-> SERIAL_OUT_OE_N && !SERIAL_OUT)
        else $error("output not released at reset");
    a_select_release: assert property ($fell(SELECT_PIN) |-> ##[1:5] SERIAL_OUT_OE_N)
        else $error("output not released after select fell");
    a_idle_released: assert property (!SELECT_PIN [*6] |-> SERIAL_OUT_OE_N)
        else $error("output driven while not selected");
    a_drive_needs_select: assert property ($fell(SERIAL_OUT_OE_N) |-> $past(SELECT_PIN, 2))
        else $error("output driven without select");
    a_drive_starts_low: assert property ($fell(SERIAL_OUT_OE_N) |-> !SERIAL_OUT)
        else $error("output did not start low");
    a_fall_on_clock: assert property (SELECT_PIN && !SERIAL_OUT_OE_N && !$past(SERIAL_OUT_OE_N)
        && $fell(SERIAL_OUT) |-> sk_recent)
        else $error("output fell without a shift clock edge");
    a_ready_holds: assert property (SELECT_PIN && !SERIAL_OUT_OE_N && SERIAL_OUT && !sk_recent
        |=> SERIAL_OUT || SERIAL_OUT_OE_N)
        else $error("ready status dropped");
    a_busy_bounded: assert property (busy_q < BUSY_MAX)
        else $error("busy status lasted too long");
endmodule

bind tweep_top tweep_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (
    .CORE_CLK(CORE_CLK), .RST(RST), .SELECT_PIN(SELECT_PIN),
    .SHIFT_CLOCK_PIN(SHIFT_CLOCK_PIN), .SERIAL_IN_PIN(SERIAL_IN_PIN),
    .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N));

// ===== bench/tweep_top_test.sv
// testbench of the three-wire serial memory port
`timescale 1ns/1ps
module tweep_top_test import tweep_pkg::*; ;
    localparam int WCYC = 100;
    logic core_clk;
    logic rst;
    logic sel;
    logic sk;
    logic di;
    logic sout;
    logic soe_n;
    int   error_cnt;
    int   cmp_count;
    wire  dwire = soe_n ? ~sout : sout;
    tweep_top #(.WRITE_CYCLES(WCYC)) i_tweep_top (.CORE_CLK(core_clk), .RST(rst),
        .SELECT_PIN(sel), .SHIFT_CLOCK_PIN(sk), .SERIAL_IN_PIN(di),
        .SERIAL_OUT(sout), .SERIAL_OUT_OE_N(soe_n));
    tweep_host i_tweep_host (.sel(sel), .sk(sk), .di(di), .dout(dwire));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic prog(input logic [24:0] v, input int n, input bit busy);
        logic [24:0] r;
        logic        first;
        logic        fin;
        int          waited;
        i_tweep_host.frame(v, n, r);
        if (busy) begin
            i_tweep_host.status(first, fin, waited);
            check("busy", {15'h0000, first}, 16'h0000);
            check("ready", {15'h0000, fin}, 16'h0001);
            check("write time", {15'h0000, waited <= WCYC}, 16'h0001);
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        logic [24:0] r;
        i_tweep_host.frame({1'b1, OP_READ, a, 16'h0000}, 25, r);
        check("dummy bit", {15'h0000, r[16]}, 16'h0000);
        check("read word", r[15:0], exp);
        check("released", {15'h0000, soe_n}, 16'h0001);
    endtask
    task automatic t_protect;
        prog({1'b1, OP_EXT, EXT_EN, 4'h0, 16'h0000}, 9, 1'b0);
        prog({1'b1, OP_WRITE, 6'h05, 16'h1234}, 25, 1'b1);
        rd(6'h05, 16'h1234);
        prog({1'b1, OP_EXT, EXT_DIS, 4'h0, 16'h0000}, 9, 1'b0);
        prog({1'b1, OP_WRITE, 6'h05, 16'hABCD}, 25, 1'b0);
        rd(6'h05, 16'h1234);
        $display("test protect done");
    endtask
    task automatic t_overwrite;
        prog({1'b1, OP_EXT, EXT_EN, 4'h0, 16'h0000}, 9, 1'b0);
        prog({1'b1, OP_WRITE, 6'h07, 16'h0F0F}, 25, 1'b1);
        prog({1'b1, OP_WRITE, 6'h07, 16'h5A5A}, 25, 1'b1);
        rd(6'h07, 16'h5A5A);
        prog({1'b1, OP_ERASE, 6'h07, 16'h0000}, 9, 1'b1);
        rd(6'h07, 16'hFFFF);
        $display("test overwrite done");
    endtask
    task automatic t_all;
        prog({1'b1, OP_EXT, EXT_FILL, 4'h0, 16'hC3C3}, 25, 1'b1);
        rd(6'h00, 16'hC3C3);
        rd(6'h3F, 16'hC3C3);
        prog({1'b1, OP_EXT, EXT_ERALL, 4'h0, 16'h0000}, 9, 1'b1);
        rd(6'h3F, 16'hFFFF);
        prog({1'b1, OP_EXT, EXT_DIS, 4'h0, 16'h0000}, 9, 1'b0);
        $display("test all words done");
    endtask
    task automatic t_partial;
        logic [24:0] r;
        i_tweep_host.frame({1'b1, OP_EXT, EXT_EN, 20'h0_0000}, 5, r);
        prog({1'b1, OP_WRITE, 6'h02, 16'h1111}, 25, 1'b0);
        rd(6'h02, 16'hFFFF);
        $display("test partial done");
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        $display("watchdog expired");
        report_and_stop();
    end
    initial begin
        rst       = 1'b1;
        error_cnt = 0;
        cmp_count = 0;
        repeat (16) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        t_protect();
        t_overwrite();
        t_all();
        t_partial();
        report_and_stop();
    end
endmodule

// ===== logic/tweep_fifo.sv
// file: small valid/ready fifo for write requests
`timescale 1ns/1ps
module tweep_fifo import tweep_pkg::*; #(
    parameter int W = 23,
    parameter int D = 4
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire           push = in_valid && in_ready;
    wire           pop  = out_valid && out_ready;

    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rp_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
            if (pop)  rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ===== logic/tweep_pkg.sv
// package: constants and types of the three-wire serial memory port
package tweep_pkg;
    localparam int WORD_W      = 16;
    localparam int ADDR_W      = 6;
    localparam int WORDS       = 64;
    localparam int ARRAY_BITS  = 1024;
    localparam int FIFO_DEPTH  = 4;
    localparam int CLK_MHZ     = 100;
    localparam int WRITE_MS    = 10;
    localparam int WRITE_CYC   = WRITE_MS * 1000 * CLK_MHZ;
    localparam int INSTR_BITS  = 9;
    localparam logic [1:0] OP_EXT    = 2'h0;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] OP_ERASE  = 2'h3;
    localparam logic [1:0] EXT_DIS   = 2'h0;
    localparam logic [1:0] EXT_FILL  = 2'h1;
    localparam logic [1:0] EXT_ERALL = 2'h2;
    localparam logic [1:0] EXT_EN    = 2'h3;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    typedef struct packed {
        logic              all;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } tweep_wr_t;

    typedef enum logic [2:0] {
        TW_IDLE  = 3'b000,
        TW_CMD   = 3'b001,
        TW_READ  = 3'b010,
        TW_DATA  = 3'b011,
        TW_WAIT  = 3'b100
    } tweep_st_t;
endpackage

// ===== logic/tweep_top.sv
// file: device-side logic of the three-wire serial memory port
`timescale 1ns/1ps

// How it works
// - array of 64 words by 16 bits, six-bit address.
// - serial activity counts only while select is high.
// - read instruction plus address shifts the stored word out.
// - writes finish on the core clock, no shift clock needed.
// - write overwrites the word directly, no erase first.
// - programming starts only when enabled; otherwise array untouched.
// - after a write starts, raising select shows ready/busy on output.
// - each write cycle ends within 10 ms, then ready.
// - output released whenever select is low.
// - start bit one, two-bit opcode, six address bits, msb first.
// - read 10, write 01, erase 11; 00 uses top address bits.
// - read sends dummy zero then 16 data bits on rising clock.
// - reset disables programming; enable holds until disable.
module tweep_top import tweep_pkg::*; #(
    parameter int WRITE_CYCLES = WRITE_CYC
) (
    input  wire logic CORE_CLK,
    input  wire logic RST,
    input  wire logic SELECT_PIN,
    input  wire logic SHIFT_CLOCK_PIN,
    input  wire logic SERIAL_IN_PIN,
    output logic      SERIAL_OUT,
    output logic      SERIAL_OUT_OE_N
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] cs_s_q;
    logic [1:0] sk_s_q;
    logic [1:0] di_s_q;
    logic       sk_last_q;
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cs_s_q    <= '0;
            sk_s_q    <= '0;
            di_s_q    <= '0;
            sk_last_q <= 1'b0;
        end else begin
            cs_s_q    <= {cs_s_q[0], SELECT_PIN};
            sk_s_q    <= {sk_s_q[0], SHIFT_CLOCK_PIN};
            di_s_q    <= {di_s_q[0], SERIAL_IN_PIN};
            sk_last_q <= sk_s_q[1];
        end
    end
    wire cs     = cs_s_q[1];
    wire di     = di_s_q[1];
    wire sk_ris = sk_s_q[1] && !sk_last_q && cs;

    // ------------------------------------------------------------
    // serial front end
    // ------------------------------------------------------------
    logic [WORD_W-1:0] mem [WORDS];
    tweep_st_t         st_q;
    logic [4:0]        cnt_q;
    logic [7:0]        cmd_q;
    logic [WORD_W-1:0] sh_q;
    logic              en_q;
    logic              out_q;
    logic              oe_n_q;
    logic              busy_q;
    logic              stat_q;
    logic [31:0]       tmr_q;
    tweep_wr_t         req;
    logic              req_valid;
    logic              req_ready;
    tweep_wr_t         job;
    logic              job_valid;
    logic              job_ready;

    wire [1:0]        op      = cmd_q[7:6];
    wire [ADDR_W-1:0] addr    = cmd_q[5:0];
    wire [7:0]        cmd_n   = {cmd_q[6:0], di};
    wire              cmd_end = (st_q == TW_CMD) && sk_ris && (cnt_q == 5'(INSTR_BITS-2));
    wire              data_end = (st_q == TW_DATA) && sk_ris && (cnt_q == 5'(WORD_W-1));
    wire              pending = busy_q || job_valid;
    wire              is_wr   = (cmd_n[7:6] == OP_WRITE) ||
                                (cmd_n[7:6] == OP_EXT && cmd_n[5:4] == EXT_FILL);
    wire              is_er   = (cmd_n[7:6] == OP_ERASE) ||
                                (cmd_n[7:6] == OP_EXT && cmd_n[5:4] == EXT_ERALL);

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st_q  <= TW_IDLE;
            cnt_q <= '0;
            cmd_q <= '0;
            sh_q  <= '0;
            en_q  <= 1'b0;
            out_q <= 1'b0;
            req_valid <= 1'b0;
            req   <= '0;
        end else begin
            req_valid <= 1'b0;
            if (!cs) begin
                st_q <= TW_IDLE;
            end else begin
                unique case (st_q)
                    TW_IDLE: if (sk_ris && di && !pending) begin
                        st_q  <= TW_CMD;
                        cnt_q <= '0;
                    end
                    TW_CMD: if (sk_ris) begin
                        cmd_q <= cmd_n;
                        cnt_q <= cnt_q + 5'h1;
                        if (cmd_end) begin
                            cnt_q <= '0;
                            if (cmd_n[7:6] == OP_READ) begin
                                sh_q  <= mem[cmd_n[5:0]];
                                out_q <= 1'b0;
                                st_q  <= TW_READ;
                            end else if (is_wr) begin
                                st_q <= TW_DATA;
                            end else begin
                                st_q <= TW_WAIT;
                                if (cmd_n[7:6] == OP_EXT && cmd_n[5:4] == EXT_EN) en_q <= 1'b1;
                                if (cmd_n[7:6] == OP_EXT && cmd_n[5:4] == EXT_DIS) en_q <= 1'b0;
                                if (is_er && en_q && req_ready) begin
                                    req_valid <= 1'b1;
                                    req <= '{all: cmd_n[7:6] == OP_EXT,
                                             addr: cmd_n[5:0], data: ERASED_WORD};
                                end
                            end
                        end
                    end
                    TW_READ: if (sk_ris) begin
                        out_q <= sh_q[WORD_W-1];
                        sh_q  <= {sh_q[WORD_W-2:0], 1'b0};
                    end
                    TW_DATA: if (sk_ris) begin
                        sh_q  <= {sh_q[WORD_W-2:0], di};
                        cnt_q <= cnt_q + 5'h1;
                        if (data_end) begin
                            st_q <= TW_WAIT;
                            if (en_q && req_ready) begin
                                req_valid <= 1'b1;
                                req <= '{all: op == OP_EXT, addr: addr,
                                         data: {sh_q[WORD_W-2:0], di}};
                            end
                        end
                    end
                    TW_WAIT: ;
                    default: st_q <= TW_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // request queue
    // ------------------------------------------------------------
    tweep_fifo #(.W($bits(tweep_wr_t)), .D(FIFO_DEPTH)) u_fifo (
        .clk       (CORE_CLK),
        .rst       (RST),
        .in_data   (req),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .out_data  (job),
        .out_valid (job_valid),
        .out_ready (job_ready)
    );
    assign job_ready = !busy_q;

    // ------------------------------------------------------------
    // self-timed programming engine
    // ------------------------------------------------------------
    tweep_wr_t  cur_q;
    wire        tmr_done = busy_q && (tmr_q == 32'(WRITE_CYCLES - 1));
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            busy_q <= 1'b0;
            tmr_q  <= '0;
            cur_q  <= '0;
        end else if (job_valid && !busy_q) begin
            busy_q <= 1'b1;
            tmr_q  <= '0;
            cur_q  <= job;
        end else if (tmr_done) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            tmr_q <= tmr_q + 32'h1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (tmr_done) begin
            for (int i = 0; i < WORDS; i++) begin
                if (cur_q.all || cur_q.addr == ADDR_W'(i)) mem[i] <= cur_q.data;
            end
        end
    end

    // ------------------------------------------------------------
    // output pin
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            SERIAL_OUT      <= 1'b0;
            SERIAL_OUT_OE_N <= 1'b1;
            stat_q          <= 1'b0;
        end else begin
            stat_q <= stat_q;
            if (!cs) begin
                SERIAL_OUT_OE_N <= 1'b1;
                stat_q          <= pending;
            end else if (st_q == TW_READ) begin
                SERIAL_OUT      <= out_q;
                SERIAL_OUT_OE_N <= 1'b0;
            end else if (stat_q && st_q == TW_IDLE) begin
                SERIAL_OUT      <= !pending;
                SERIAL_OUT_OE_N <= 1'b0;
            end else begin
                SERIAL_OUT_OE_N <= 1'b1;
            end
        end
    end
endmodule
